// ===== verilog/phymcr_mgmt_bank.sv
// management register bank of the transceiver: control, status and mii/line gating
`timescale 1ns/1ns
`default_nettype none
`include "phymcr_map.svh"
module phymcr_mgmt_bank #(
  parameter logic [15:0] ID_HIGH = 16'h5A5A, // arbitrary identity value
  parameter logic [15:0] ID_LOW = 16'hA5A0 // arbitrary identity value
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire phymcr_pkg::phymcr_addr_t strap_phy_addr,
  input wire logic strap_aneg_en,
  input wire logic strap_speed_100,
  input wire logic strap_full_duplex,
  input wire logic [6:0] status_low,
  input wire logic aneg_speed_100,
  input wire logic aneg_full_duplex,
  input wire logic [3:0] mii_txd_in,
  input wire logic mii_tx_en_in,
  input wire logic mii_tx_er_in,
  input wire logic phy_col_in,
  input wire logic phy_crs_in,
  output logic [3:0] dp_txd,
  output logic dp_tx_en,
  output logic dp_tx_er,
  output logic mii_col_out,
  output logic mii_crs_out,
  output logic mii_out_oe_n,
  output logic line_tx_oe_n,
  output logic led_oe_n,
  output logic loopback_en,
  output logic speed_100,
  output logic full_duplex,
  output logic negotiation_enable,
  output logic negotiation_restart,
  output logic power_down,
  output logic device_reset
);
  import phymcr_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  phymcr_mgmt_if mgmt ();
  logic strap_done_q;
  phymcr_addr_t phy_addr_q;
  logic loopback_select_q;
  logic speed_select_q;
  logic negotiation_enable_q;
  logic power_down_select_q;
  logic isolate_select_q;
  logic duplex_select_q;
  logic collision_test_enable_q;
  phymcr_word_t adv_q;
  phymcr_word_t irq_enable_q;
  phymcr_word_t fast_ctrl_q;
  phymcr_word_t mode_ctrl_q;
  logic rst_start;
  logic rst_busy;
  logic rst_done;
  logic restart_start;
  logic restart_busy;
  logic restart_done;
  logic ctrl_wr;
  logic mii_block;
  phymcr_word_t ctrl_rd;
  phymcr_word_t stat_rd;

  // ---------------------------------------------------------------------------
  // serial management access and self-clearing timers
  // ---------------------------------------------------------------------------
  phymcr_mdio_frame u_frame (
    .ref_clk(ref_clk),
    .reset(reset),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .phy_addr(phy_addr_q),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n),
    .mgmt(mgmt.frame)
  );

  // soft reset is held for a fixed time, then the bank reloads
  phymcr_hold_timer #(.CYCLES(`PHYMCR_SRST_CYC)) u_srst (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(rst_start),
    .busy(rst_busy),
    .done(rst_done)
  );

  phymcr_hold_timer #(.CYCLES(`PHYMCR_RESTART_CYC)) u_restart (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(restart_start),
    .busy(restart_busy),
    .done(restart_done)
  );

  // writes are ignored while a soft reset runs
  assign ctrl_wr = mgmt.wr_stb && (mgmt.addr == `PHYMCR_REG_CTRL) && !rst_busy;
  assign rst_start = ctrl_wr && mgmt.wdata[`PHYMCR_CTRL_RST];
  assign restart_start = ctrl_wr && mgmt.wdata[`PHYMCR_CTRL_RESTART];

  // ---------------------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------------------
  // control word as seen by a reader; self-clearing bits show their timers
  function automatic phymcr_word_t ctrl_word(input logic rb, input logic sb);
    ctrl_word = 16'h0000;
    ctrl_word[`PHYMCR_CTRL_RST] = rb;
    ctrl_word[`PHYMCR_CTRL_LOOP] = loopback_select_q;
    ctrl_word[`PHYMCR_CTRL_SPEED] = speed_select_q;
    ctrl_word[`PHYMCR_CTRL_ANEG] = negotiation_enable_q;
    ctrl_word[`PHYMCR_CTRL_PDOWN] = power_down_select_q;
    ctrl_word[`PHYMCR_CTRL_ISO] = isolate_select_q;
    ctrl_word[`PHYMCR_CTRL_RESTART] = sb;
    ctrl_word[`PHYMCR_CTRL_DUPLEX] = duplex_select_q;
    ctrl_word[`PHYMCR_CTRL_COLTEST] = collision_test_enable_q;
  endfunction : ctrl_word

  assign ctrl_rd = ctrl_word(rst_busy, restart_busy);
  assign stat_rd = {1'b0, 4'hF, 4'h0, status_low};

  // eleven sixteen-bit registers; everything else reads zero
  always_comb begin
    case (mgmt.addr)
      `PHYMCR_REG_CTRL: mgmt.rdata = ctrl_rd;
      `PHYMCR_REG_STAT: mgmt.rdata = stat_rd;
      `PHYMCR_REG_IDH: mgmt.rdata = ID_HIGH;
      `PHYMCR_REG_IDL: mgmt.rdata = ID_LOW;
      `PHYMCR_REG_ADV: mgmt.rdata = adv_q;
      `PHYMCR_REG_LPA: mgmt.rdata = 16'h0000;
      `PHYMCR_REG_EXP: mgmt.rdata = 16'h0000;
      `PHYMCR_REG_CFGIRQ: mgmt.rdata = 16'h0000;
      `PHYMCR_REG_IRQEN: mgmt.rdata = irq_enable_q;
      `PHYMCR_REG_FAST: mgmt.rdata = fast_ctrl_q;
      `PHYMCR_REG_MODE: mgmt.rdata = mode_ctrl_q;
      default: mgmt.rdata = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------------
  // straps load once after reset release and again after a soft reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_done_q <= 1'b0;
      phy_addr_q <= 5'h00;
      loopback_select_q <= 1'b0;
      speed_select_q <= `PHYMCR_SPEED_RST;
      negotiation_enable_q <= `PHYMCR_ANEG_RST;
      power_down_select_q <= 1'b0;
      isolate_select_q <= 1'b0;
      duplex_select_q <= 1'b0;
      collision_test_enable_q <= 1'b0;
    end else if (rst_done) begin
      strap_done_q <= 1'b0;
      loopback_select_q <= 1'b0;
      power_down_select_q <= 1'b0;
      collision_test_enable_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      phy_addr_q <= strap_phy_addr;
      speed_select_q <= strap_speed_100;
      negotiation_enable_q <= strap_aneg_en;
      duplex_select_q <= strap_full_duplex;
      isolate_select_q <= (strap_phy_addr == 5'h00);
    end else if (ctrl_wr) begin
      loopback_select_q <= mgmt.wdata[`PHYMCR_CTRL_LOOP];
      speed_select_q <= mgmt.wdata[`PHYMCR_CTRL_SPEED];
      negotiation_enable_q <= mgmt.wdata[`PHYMCR_CTRL_ANEG];
      power_down_select_q <= mgmt.wdata[`PHYMCR_CTRL_PDOWN];
      isolate_select_q <= mgmt.wdata[`PHYMCR_CTRL_ISO];
      duplex_select_q <= mgmt.wdata[`PHYMCR_CTRL_DUPLEX];
      collision_test_enable_q <= mgmt.wdata[`PHYMCR_CTRL_COLTEST];
    end
  end

  // ---------------------------------------------------------------------------
  // other writable registers; status and identifier writes fall through unused
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      adv_q <= `PHYMCR_ADV_RST;
      irq_enable_q <= 16'h0000;
      fast_ctrl_q <= 16'h0000;
      mode_ctrl_q <= 16'h0000;
    end else if (rst_done) begin
      adv_q <= `PHYMCR_ADV_RST;
      irq_enable_q <= 16'h0000;
      fast_ctrl_q <= 16'h0000;
      mode_ctrl_q <= 16'h0000;
    end else if (mgmt.wr_stb && !rst_busy) begin
      case (mgmt.addr)
        `PHYMCR_REG_ADV: adv_q <= mgmt.wdata;
        `PHYMCR_REG_IRQEN: irq_enable_q <= mgmt.wdata;
        `PHYMCR_REG_FAST: fast_ctrl_q <= mgmt.wdata;
        `PHYMCR_REG_MODE: mode_ctrl_q <= mgmt.wdata;
        default: adv_q <= adv_q;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // datapath steering
  // ---------------------------------------------------------------------------
  // forced speed and duplex only apply with negotiation off
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      loopback_en <= 1'b0;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
      negotiation_enable <= 1'b0;
      negotiation_restart <= 1'b0;
      power_down <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      loopback_en <= loopback_select_q;
      speed_100 <= negotiation_enable_q ? aneg_speed_100 : speed_select_q;
      full_duplex <= negotiation_enable_q ? aneg_full_duplex : duplex_select_q;
      negotiation_enable <= negotiation_enable_q;
      negotiation_restart <= restart_done;
      power_down <= power_down_select_q;
      device_reset <= rst_busy;
    end
  end

  // ---------------------------------------------------------------------------
  // mii and line gating
  // ---------------------------------------------------------------------------
  assign mii_block = isolate_select_q | power_down_select_q;

  // isolation drops transmit inputs and floats mii outputs; management keeps running
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dp_txd <= 4'h0;
      dp_tx_en <= 1'b0;
      dp_tx_er <= 1'b0;
      mii_col_out <= 1'b0;
      mii_crs_out <= 1'b0;
      mii_out_oe_n <= 1'b1;
      line_tx_oe_n <= 1'b1;
      led_oe_n <= 1'b1;
    end else begin
      dp_txd <= mii_block ? 4'h0 : mii_txd_in;
      dp_tx_en <= mii_block ? 1'b0 : mii_tx_en_in;
      dp_tx_er <= mii_block ? 1'b0 : mii_tx_er_in;
      mii_col_out <= mii_block ? 1'b0 : (collision_test_enable_q ? mii_tx_en_in : phy_col_in);
      mii_crs_out <= mii_block ? 1'b0 : phy_crs_in;
      mii_out_oe_n <= mii_block;
      line_tx_oe_n <= power_down_select_q;
      led_oe_n <= power_down_select_q;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_col_test_follow: assert property (collision_test_enable_q && !mii_block && mii_tx_en_in |=> mii_col_out)
    else $error("collision test did not follow transmit enable");
  a_col_test_drop: assert property (collision_test_enable_q && !mii_block && !mii_tx_en_in |=> !mii_col_out)
    else $error("collision test held collision without transmit enable");
  a_isolate_float: assert property (isolate_select_q |=> mii_out_oe_n && !dp_tx_en && !mii_col_out)
    else $error("isolated mii still driven");
  a_pdown_float: assert property ($rose(power_down_select_q) |=> line_tx_oe_n && led_oe_n && mii_out_oe_n)
    else $error("power-down left line or led drivers on");
  a_stat_abil_bits: assert property (mgmt.addr == `PHYMCR_REG_STAT |-> mgmt.rdata[15:11] == `PHYMCR_STAT_ABIL)
    else $error("status ability bits wrong");
  a_reserved_zero: assert property (ctrl_rd[6:0] == 7'h00 && stat_rd[10:7] == 4'h0)
    else $error("reserved bits not zero");
  a_srst_reload: assert property (rst_done |-> ##2 !ctrl_rd[15] && negotiation_enable_q == $past(strap_aneg_en))
    else $error("soft reset did not clear itself and reload straps");
  a_restart_pulse: assert property (restart_start |=> restart_busy [*2] ##[1:3] negotiation_restart)
    else $error("negotiation restart did not complete");
  a_speed_forced: assert property (!negotiation_enable_q |=> speed_100 == $past(speed_select_q))
    else $error("forced speed not applied");
  a_duplex_forced: assert property (!negotiation_enable_q |=> full_duplex == $past(duplex_select_q))
    else $error("forced duplex not applied");
  a_zero_addr_iso: assert property (!strap_done_q && !rst_done && strap_phy_addr == 5'h00 |=> isolate_select_q)
    else $error("zero strapped address did not isolate");
  a_srst_hold: assert property (rst_busy |=> $stable(loopback_select_q) && $stable(isolate_select_q))
    else $error("control changed while soft reset ran");
  a_loop_follow: assert property (1'b1 |=> loopback_en == $past(loopback_select_q))
    else $error("loop-back output did not follow control");

  c_coll_test: cover property (collision_test_enable_q && mii_tx_en_in ##1 mii_col_out);
  c_soft_reset: cover property (rst_start ##1 rst_busy);
  c_status_read: cover property (mgmt.addr == `PHYMCR_REG_STAT && $fell(mdio_oe_n));
  c_restart: cover property (negotiation_restart);
endmodule : phymcr_mgmt_bank
`default_nettype wire

// ===== verilog/phymcr_map.svh
// register indexes, field positions, reset values and timing counts of the management bank
`ifndef PHYMCR_MAP_SVH
`define PHYMCR_MAP_SVH
// Summary of operation
// - eleven management registers are present, each sixteen bits wide
// - indexes 0..6 are the standard set, 17..20 the vendor set
// - control bit 15 resets the device and clears itself afterwards; default zero
// - control bit 14 selects loop-back when one, normal when zero; default zero
// - control bit 13 forces 100 Mbps when one; ignored while negotiation enabled; default one
// - control bit 12 enables auto-negotiation when one; default one
// - control bit 11 powers down: line and led drivers float, mii isolated
// - control bit 10 isolates the mii; management interface stays alive
// - control bit 9 restarts negotiation and clears itself once restarted
// - control bit 8 forces full duplex; ignored while negotiation enabled; default zero
// - control bit 7 makes collision follow transmit enable
// - the status register is read only; writes change nothing
// - status bit 15 always reads zero, no four-pair ability
// - status bits 14..11 always read one, the four duplex abilities
// - straps load initial control values at reset; management writes take over
// - an all-zero strapped address starts the device isolated
// ---------------------------------------------------------------------------
// register indexes
// ---------------------------------------------------------------------------
`define PHYMCR_REG_CTRL 5'h00
`define PHYMCR_REG_STAT 5'h01
`define PHYMCR_REG_IDH 5'h02
`define PHYMCR_REG_IDL 5'h03
`define PHYMCR_REG_ADV 5'h04
`define PHYMCR_REG_LPA 5'h05
`define PHYMCR_REG_EXP 5'h06
`define PHYMCR_REG_CFGIRQ 5'h11
`define PHYMCR_REG_IRQEN 5'h12
`define PHYMCR_REG_FAST 5'h13
`define PHYMCR_REG_MODE 5'h14
// ---------------------------------------------------------------------------
// control fields and reset values
// ---------------------------------------------------------------------------
`define PHYMCR_CTRL_RST 15
`define PHYMCR_CTRL_LOOP 14
`define PHYMCR_CTRL_SPEED 13
`define PHYMCR_CTRL_ANEG 12
`define PHYMCR_CTRL_PDOWN 11
`define PHYMCR_CTRL_ISO 10
`define PHYMCR_CTRL_RESTART 9
`define PHYMCR_CTRL_DUPLEX 8
`define PHYMCR_CTRL_COLTEST 7
`define PHYMCR_SPEED_RST 1'b1
`define PHYMCR_ANEG_RST 1'b1
`define PHYMCR_STAT_ABIL 5'h0F
`define PHYMCR_ADV_RST 16'h01E1
// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define PHYMCR_CLK_NS 8
`define PHYMCR_SRST_NS 2000
`define PHYMCR_SRST_CYC 12'((`PHYMCR_SRST_NS + `PHYMCR_CLK_NS - 1) / `PHYMCR_CLK_NS)
`define PHYMCR_RESTART_CYC 12'h002
`endif

// ===== verilog/phymcr_pkg.sv
// types shared by the management bank modules
`default_nettype none
package phymcr_pkg;
  typedef logic [15:0] phymcr_word_t;
  typedef logic [4:0] phymcr_addr_t;
  typedef enum logic [2:0] {MF_IDLE, MF_START, MF_HDR, MF_TA, MF_RDATA, MF_WDATA} phymcr_mf_state_t;
endpackage : phymcr_pkg
`default_nettype wire

// ===== verilog/phymcr_mgmt_if.sv
// register access carrier between the serial frame engine and the register bank
`timescale 1ns/1ns
`default_nettype none
interface phymcr_mgmt_if;
  import phymcr_pkg::*;
  phymcr_addr_t addr;
  phymcr_word_t wdata;
  logic wr_stb;
  phymcr_word_t rdata;
  modport frame (output addr, output wdata, output wr_stb, input rdata);
  modport bank (input addr, input wdata, input wr_stb, output rdata);
endinterface : phymcr_mgmt_if
`default_nettype wire

// ===== verilog/phymcr_hold_timer.sv
// down counter that holds busy for a fixed number of cycles and pulses done at the end
`timescale 1ns/1ns
`default_nettype none
module phymcr_hold_timer #(
  parameter logic [11:0] CYCLES = 12'h001
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [11:0] count_q;

  // a new start reloads the count even while busy
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_q <= 12'h000;
      done <= 1'b0;
    end else begin
      done <= (count_q == 12'h001);
      if (start) begin
        count_q <= CYCLES;
      end else if (count_q != 12'h000) begin
        count_q <= count_q - 12'h001;
      end
    end
  end

  assign busy = (count_q != 12'h000);
endmodule : phymcr_hold_timer
`default_nettype wire

// ===== verilog/phymcr_mdio_frame.sv
// serial management frame engine: start, opcode, addresses, turnaround, data
`timescale 1ns/1ns
`default_nettype none
module phymcr_mdio_frame (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire phymcr_pkg::phymcr_addr_t phy_addr,
  output logic mdio_out,
  output logic mdio_oe_n,
  phymcr_mgmt_if.frame mgmt
);
  import phymcr_pkg::*;
  phymcr_mf_state_t state_q;
  logic mdc_q;
  logic one_q;
  logic hit_q;
  logic rd_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic rise;

  // management clock edge, sampled as a plain input
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end
  assign rise = mdc & ~mdc_q;

  // frame walker; a preamble of ones (even suppressed to one idle bit) precedes the start
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= MF_IDLE;
      one_q <= 1'b0;
      hit_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      mgmt.addr <= 5'h00;
      mgmt.wdata <= 16'h0000;
      mgmt.wr_stb <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe_n <= 1'b1;
    end else begin
      mgmt.wr_stb <= 1'b0;
      if (rise) begin
        unique case (state_q)
          MF_IDLE: begin
            one_q <= mdio_in;
            if (one_q && !mdio_in) begin
              state_q <= MF_START;
            end
          end
          MF_START: begin
            cnt_q <= 5'h00;
            state_q <= mdio_in ? MF_HDR : MF_IDLE;
          end
          MF_HDR: begin
            sh_q <= {sh_q[14:0], mdio_in};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h0B) begin
              rd_q <= (sh_q[10:9] == 2'h2);
              hit_q <= (sh_q[8:4] == phy_addr) && (sh_q[10:9] == 2'h2 || sh_q[10:9] == 2'h1);
              mgmt.addr <= {sh_q[3:0], mdio_in};
              cnt_q <= 5'h00;
              state_q <= MF_TA;
            end
          end
          MF_TA: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h00 && rd_q && hit_q) begin
              mdio_oe_n <= 1'b0;
              mdio_out <= 1'b0;
            end
            if (cnt_q == 5'h01) begin
              cnt_q <= 5'h00;
              if (rd_q && hit_q) begin
                sh_q <= {mgmt.rdata[14:0], 1'b0};
                mdio_out <= mgmt.rdata[15];
                state_q <= MF_RDATA;
              end else begin
                state_q <= MF_WDATA;
              end
            end
          end
          MF_RDATA: begin
            cnt_q <= cnt_q + 5'h01;
            mdio_out <= sh_q[15];
            sh_q <= {sh_q[14:0], 1'b0};
            if (cnt_q == 5'h0F) begin
              mdio_oe_n <= 1'b1;
              one_q <= 1'b0;
              state_q <= MF_IDLE;
            end
          end
          MF_WDATA: begin
            cnt_q <= cnt_q + 5'h01;
            sh_q <= {sh_q[14:0], mdio_in};
            if (cnt_q == 5'h0F) begin
              mgmt.wr_stb <= hit_q && !rd_q;
              mgmt.wdata <= {sh_q[14:0], mdio_in};
              one_q <= 1'b0;
              state_q <= MF_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : phymcr_mdio_frame
`default_nettype wire

// ===== tb/phymcr_sta_model.sv
// station manager model: drives mdc and the master side of the mdio wire
`timescale 1ns/1ns
`default_nettype none
module phymcr_sta_model (
  input wire logic ref_clk,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output var logic mdc,
  output wire logic mdio_in
);
  logic drv = 1'b0;
  logic bit_v = 1'b1;
  // wire level: device when enabled, else master, else the pull-up
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? bit_v : 1'b1);
  initial begin
    mdc = 1'b0;
  end
  // one mdc period of 8 clocks; bit set while low, wire sampled at the rise
  task automatic clk_bit(input logic b, input logic d, output logic s);
    @(negedge ref_clk);
    mdc = 1'b0;
    drv = d;
    bit_v = b;
    repeat (4) @(negedge ref_clk);
    mdc = 1'b1;
    s = mdio_in;
    repeat (3) @(negedge ref_clk);
  endtask : clk_bit
  // whole frame with short preamble; released from turnaround on reads
  task automatic frame(input logic [4:0] pa, input logic rd, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rv);
    logic [35:0] f;
    logic s;
    f = {4'hF, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
    for (int i = 35; i >= 0; i--) begin
      clk_bit(f[i], !rd || i > 17, s);
      if (i < 16) rv[i] = s;
    end
    clk_bit(1'b1, 1'b0, s); // idle bit between frames
    @(negedge ref_clk);
    mdc = 1'b0; // clock stands still outside frames
  endtask : frame
endmodule : phymcr_sta_model
`default_nettype wire

// ===== tb/test_phy_mgmt_control_status_regs.sv
// self-checking bench of the management bank against a register model
`timescale 1ns/1ns
`default_nettype none
`define TB_CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module test_phy_mgmt_control_status_regs;
  import phymcr_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic mdc, mdio_in, mdio_out, mdio_oe_n;
  phymcr_addr_t strap_phy_addr = 5'h01;
  logic strap_aneg_en = 1'b1;
  logic strap_speed_100 = 1'b1;
  logic strap_full_duplex = 1'b0;
  logic aneg_speed_100 = 1'b0;
  logic aneg_full_duplex = 1'b0;
  logic [6:0] status_low = 7'h00;
  logic [3:0] mii_txd_in = 4'h0;
  logic mii_tx_en_in = 1'b0;
  logic mii_tx_er_in = 1'b0;
  logic phy_col_in = 1'b0;
  logic phy_crs_in = 1'b0;
  logic [3:0] dp_txd;
  logic dp_tx_en, dp_tx_er, mii_col_out, mii_crs_out, mii_out_oe_n, line_tx_oe_n, led_oe_n;
  logic loopback_en, speed_100, full_duplex, negotiation_enable, negotiation_restart, power_down, device_reset;
  logic [15:0] mdl [32];
  logic [15:0] v;
  logic [31:0] rs = 32'h0000D89D;
  int idx [12] = '{0, 1, 2, 3, 4, 5, 6, 17, 18, 19, 20, 7};
  int failures = 0;
  int n_checks = 0;
  int n, n_rst, n_dr;
  // clock and monitors of the restart pulse and the soft reset length
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (negotiation_restart === 1'b1) n_rst++;
    if (device_reset === 1'b1) n_dr++;
  end
  phymcr_sta_model sta (.ref_clk, .mdio_out, .mdio_oe_n, .mdc, .mdio_in);
  phymcr_mgmt_bank #(.ID_HIGH(16'h1357), .ID_LOW(16'h2468)) dut ( // arbitrary identity values
    .ref_clk, .reset, .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .strap_phy_addr, .strap_aneg_en,
    .strap_speed_100, .strap_full_duplex, .status_low, .aneg_speed_100, .aneg_full_duplex,
    .mii_txd_in, .mii_tx_en_in, .mii_tx_er_in, .phy_col_in, .phy_crs_in, .dp_txd, .dp_tx_en,
    .dp_tx_er, .mii_col_out, .mii_crs_out, .mii_out_oe_n, .line_tx_oe_n, .led_oe_n, .loopback_en,
    .speed_100, .full_duplex, .negotiation_enable, .negotiation_restart, .power_down, .device_reset);
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  // model contents after any reset, control taken from the straps
  task automatic defaults;
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[0] = {2'b00, strap_speed_100, strap_aneg_en, 1'b0, strap_phy_addr == 5'h00, 1'b0,
              strap_full_duplex, 8'h00};
    mdl[2] = 16'h1357;
    mdl[3] = 16'h2468;
    mdl[4] = 16'h01E1;
  endtask : defaults
  task automatic do_reset;
    reset = 1'b1;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    defaults();
  endtask : do_reset
  // write; the model keeps only the writable bits of each index
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] m;
    m = ra == 5'h00 ? 16'h7D80 : (ra == 5'h04 || (ra >= 5'h12 && ra <= 5'h14)) ? 16'hFFFF : 16'h0000;
    sta.frame(strap_phy_addr, 1'b0, ra, d, v);
    mdl[ra] = (mdl[ra] & ~m) | (d & m);
  endtask : wr
  task automatic rd_all;
    foreach (idx[i]) begin
      sta.frame(strap_phy_addr, 1'b1, 5'(idx[i]), 16'h0000, v);
      mdl[1] = {1'b0, 4'hF, 4'h0, status_low};
      `TB_CHK(v, mdl[idx[i]])
    end
  endtask : rd_all
  // port effects of the control bits
  task automatic chk_out;
    logic [15:0] c;
    logic iso;
    repeat (3) @(negedge ref_clk);
    c = mdl[0];
    iso = c[11] | c[10];
    `TB_CHK(loopback_en, c[14])
    `TB_CHK(speed_100, c[12] ? aneg_speed_100 : c[13])
    `TB_CHK(negotiation_enable, c[12])
    `TB_CHK({line_tx_oe_n, led_oe_n, power_down, mii_out_oe_n}, {c[11], c[11], c[11], iso})
    `TB_CHK({mii_crs_out, dp_tx_er, dp_tx_en, dp_txd}, {phy_crs_in, mii_tx_er_in, mii_tx_en_in, mii_txd_in} & {7{!iso}})
    `TB_CHK(full_duplex, c[12] ? aneg_full_duplex : c[8])
    `TB_CHK(mii_col_out, !iso & (c[7] ? mii_tx_en_in : phy_col_in))
  endtask : chk_out
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // main sequence: defaults, random rounds, forced modes, restart, soft reset, strap isolate
  initial begin
    do_reset();
    rd_all();
    chk_out();
    for (int r = 0; r < 4; r++) begin
      {status_low, aneg_speed_100, aneg_full_duplex, mii_txd_in, mii_tx_en_in, mii_tx_er_in, phy_crs_in,
       phy_col_in} = 17'(rnd());
      foreach (idx[i]) wr(5'(idx[i]), idx[i] == 0 ? 16'(rnd()) & 16'h7DFF : 16'(rnd()));
      rd_all();
      chk_out();
    end
    mii_tx_en_in = 1'b1;
    wr(5'h00, 16'h2180);
    chk_out();
    n_rst = 0;
    wr(5'h00, mdl[0] | 16'h0200);
    repeat (4) @(negedge ref_clk);
    `TB_CHK(n_rst, 1)
    rd_all();
    n_dr = 0;
    wr(5'h00, 16'h8000);
    // read back while the soft reset still runs: bit 15 stands, the rest as written
    sta.frame(strap_phy_addr, 1'b1, 5'h00, 16'h0000, v);
    `TB_CHK(v, 16'h8000)
    for (n = 0; n < 400 && device_reset === 1'b1; n++) @(negedge ref_clk);
    if (n == 400) begin
      $display("mismatch t=%0t soft reset did not end", $time);
      failures++;
      end_sim();
    end
    `TB_CHK(n_dr, 250)
    defaults();
    rd_all();
    sta.frame(strap_phy_addr ^ 5'h01, 1'b1, 5'h00, 16'h0000, v);
    `TB_CHK(v, 16'hFFFF)
    strap_phy_addr = 5'h00;
    {strap_aneg_en, strap_speed_100, strap_full_duplex} = 3'(rnd());
    do_reset();
    rd_all();
    chk_out();
    end_sim();
  end
endmodule : test_phy_mgmt_control_status_regs
`default_nettype wire
